// File: ftl_link.sv
// Tone-coded remote link: encoder, pattern checker, good/bad counters, one-shot, registers.
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "ftl_defines.svh"

module ftl_link #(
    parameter int ONESHOT_CYC = `FTL_ONESHOT_US * `FTL_CLK_MHZ
) (
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    input  wire logic        ce_i,
    input  wire logic        key_i,
    input  wire logic        test_i,
    input  wire logic [8:0]  enc_sel_i,
    input  wire logic [8:0]  dec_sel_i,
    input  wire logic        rx_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        we_i,
    input  wire logic        re_i,
    output logic [31:0]      rdata_o,
    output logic             tx_o,
    output logic             valid_o,
    output logic             locked_o
);
    localparam int PW = $bits(ftl_pkg::ftl_pins_t);
    localparam logic [23:0] OS_RST = ONESHOT_CYC[23:0];

    ftl_pkg::ftl_pins_t     pins_raw;
    ftl_pkg::ftl_pins_t     pins;
    logic [PW-1:0]          s1_q;
    logic [PW-1:0]          s2_q;
    logic [PW-1:0]          s3_q;
    logic [PW-1:0]          pin_q;

    logic [1:0]             ctrl_q;
    logic [23:0]            oneshot_q;
    logic [15:0]            good_tot_q;
    logic [15:0]            bad_tot_q;

    ftl_pkg::ftl_sym_ev_t   ev;
    ftl_pkg::ftl_cmp_state_t cmp_q;
    logic [3:0]             idx_q;
    logic                   mis_q;
    logic                   done_q;
    logic                   pass_q;
    logic [14:0]            expect_pat;
    logic                   rx_bit;
    logic                   sym_data;

    logic [2:0]             good_q;
    logic [2:0]             bad_q;
    logic                   holdoff_q;
    logic [23:0]            os_cnt_q;
    logic                   os_last;
    logic                   third_bad;
    logic                   retrig;
    logic                   fire;
    logic                   on_end;
    logic                   kill;

    logic                   enc_active;
    logic [31:0]            rd_mux;

    // Pins gathered so one filter covers them all
    assign pins_raw = '{key: key_i, test: test_i, enc_sel: enc_sel_i, dec_sel: dec_sel_i, rx: rx_i};
    assign pins     = ftl_pkg::ftl_pins_t'(pin_q);

    // Three-stage filter per pin; a change counts once stages two and three agree
    genvar g;
    generate
        for (g = 0; g < PW; g = g + 1) begin : g_pin
            always_ff @(posedge clk_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    s1_q[g]  <= 1'b0;
                    s2_q[g]  <= 1'b0;
                    s3_q[g]  <= 1'b0;
                    pin_q[g] <= 1'b0;
                end else if (ce_i) begin
                    s1_q[g] <= pins_raw[g];
                    s2_q[g] <= s1_q[g];
                    s3_q[g] <= s2_q[g];
                    if (s2_q[g] == s3_q[g]) begin
                        pin_q[g] <= s3_q[g];
                    end
                end
            end
        end
    endgenerate

    // Push button or software request keeps the encoder sending
    assign enc_active = pins.key || ctrl_q[`FTL_CTRL_SEND];

    // Transmit side
    ftl_encoder u_enc (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .ce_i     (ce_i),
        .active_i (enc_active),
        .test_i   (pins.test),
        .sel_i    (pins.enc_sel),
        .tx_o     (tx_o)
    );

    // Receive side: tone periods into symbols
    ftl_tone_rx u_rx (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .ce_i     (ce_i),
        .en_i     (ctrl_q[`FTL_CTRL_DEC_EN]),
        .rx_i     (pins.rx),
        .ev_o     (ev)
    );

    // Local reference: fixed ones, mask bits, selection pins
    assign expect_pat = ftl_pkg::ftl_pattern_f(`FTL_MASK_BITS, pins.dec_sel);
    assign rx_bit     = (ev.kind == ftl_pkg::SYM_ONE);
    assign sym_data   = (ev.kind == ftl_pkg::SYM_ONE) || (ev.kind == ftl_pkg::SYM_ZERO);

    // Lock follows every good symbol, one, zero or sync; any broken symbol drops it
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            locked_o <= 1'b0;
        end else if (ce_i) begin
            if (!ctrl_q[`FTL_CTRL_DEC_EN]) begin
                locked_o <= 1'b0;
            end else if (ev.stb) begin
                locked_o <= (ev.kind != ftl_pkg::SYM_BAD);
            end
        end
    end

    // Pattern checker: only steps on symbol strobes from the tone receiver
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cmp_q  <= ftl_pkg::CMP_HUNT;
            idx_q  <= 4'h0;
            mis_q  <= 1'b0;
            done_q <= 1'b0;
            pass_q <= 1'b0;
        end else if (ce_i) begin
            done_q <= 1'b0;
            if (!ctrl_q[`FTL_CTRL_DEC_EN]) begin
                cmp_q <= ftl_pkg::CMP_HUNT;
            end else if (ev.stb) begin
                case (ev.kind)
                    ftl_pkg::SYM_SYNC: begin
                        // Sync closes one pattern and opens the next
                        if (cmp_q == ftl_pkg::CMP_RECV) begin
                            done_q <= 1'b1;
                            pass_q <= (idx_q == `FTL_BIT_LAST) && !mis_q;
                        end
                        cmp_q <= ftl_pkg::CMP_RECV;
                        idx_q <= 4'h0;
                        mis_q <= 1'b0;
                    end
                    ftl_pkg::SYM_ONE,
                    ftl_pkg::SYM_ZERO: begin
                        if (cmp_q == ftl_pkg::CMP_RECV) begin
                            if (idx_q == `FTL_BIT_LAST) begin
                                // Data where sync belongs: pattern broken
                                done_q <= 1'b1;
                                pass_q <= 1'b0;
                                cmp_q  <= ftl_pkg::CMP_HUNT;
                            end else begin
                                mis_q <= mis_q || (rx_bit != expect_pat[idx_q]);
                                idx_q <= idx_q + 4'h1;
                            end
                        end
                    end
                    default: begin
                        if (cmp_q == ftl_pkg::CMP_RECV) begin
                            done_q <= 1'b1;
                            pass_q <= 1'b0;
                        end
                        cmp_q <= ftl_pkg::CMP_HUNT;
                    end
                endcase
            end
        end
    end

    // Events seen by the counters and the one-shot
    assign third_bad = done_q && !pass_q && (bad_q >= (`FTL_BAD_TRIG - 3'h1));
    assign os_last   = (os_cnt_q <= 24'h000001);
    assign retrig    = valid_o && done_q && pass_q;
    assign fire      = !valid_o && !holdoff_q && (good_q >= `FTL_GOOD_TRIG);
    assign on_end    = valid_o && os_last && !retrig;
    assign kill      = valid_o && third_bad;

    // Good and bad pattern counters, saturating at 3 bits
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            good_q <= 3'h0;
            bad_q  <= 3'h0;
        end else if (ce_i) begin
            if (done_q && pass_q) begin
                bad_q <= 3'h0;
            end else if (done_q && (bad_q != `FTL_CNT_MAX)) begin
                bad_q <= bad_q + 3'h1;
            end
            // A fresh run of good patterns is needed after each off edge
            if (third_bad || on_end) begin
                good_q <= 3'h0;
            end else if (done_q && pass_q && (good_q != `FTL_CNT_MAX)) begin
                good_q <= good_q + 3'h1;
            end
        end
    end

    // Retriggerable one-shot with an off hold of one full period after it ends
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            valid_o   <= 1'b0;
            holdoff_q <= 1'b0;
            os_cnt_q  <= 24'h000000;
        end else if (ce_i) begin
            if (kill || on_end) begin
                valid_o   <= 1'b0;
                holdoff_q <= 1'b1;
                os_cnt_q  <= oneshot_q;
            end else if (fire) begin
                valid_o  <= 1'b1;
                os_cnt_q <= oneshot_q;
            end else if (retrig) begin
                os_cnt_q <= oneshot_q;
            end else if (holdoff_q && os_last) begin
                holdoff_q <= 1'b0;
                os_cnt_q  <= 24'h000000;
            end else if (os_cnt_q != 24'h000000) begin
                os_cnt_q <= os_cnt_q - 24'h000001;
            end
        end
    end

    // Pattern statistics; a write to the register clears both
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            good_tot_q <= 16'h0000;
            bad_tot_q  <= 16'h0000;
        end else if (ce_i) begin
            if (we_i && (addr_i == `FTL_A_PATCNT)) begin
                good_tot_q <= 16'h0000;
                bad_tot_q  <= 16'h0000;
            end else if (done_q && pass_q && (good_tot_q != 16'hffff)) begin
                good_tot_q <= good_tot_q + 16'h0001;
            end else if (done_q && !pass_q && (bad_tot_q != 16'hffff)) begin
                bad_tot_q <= bad_tot_q + 16'h0001;
            end
        end
    end

    // Control register: software send and decoder enable
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_q <= `FTL_CTRL_RST;
        end else if (ce_i && we_i && (addr_i == `FTL_A_CTRL)) begin
            ctrl_q <= wdata_i[1:0];
        end
    end

    // One-shot period; a new value takes effect at the next load
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            oneshot_q <= OS_RST;
        end else if (ce_i && we_i && (addr_i == `FTL_A_ONESHOT)) begin
            oneshot_q <= wdata_i[23:0];
        end
    end

    // Read decode; unmapped addresses read zero
    always_comb begin
        rd_mux = 32'h00000000;
        case (addr_i)
            `FTL_A_CTRL: begin
                rd_mux[1:0] = ctrl_q;
            end
            `FTL_A_ONESHOT: begin
                rd_mux[23:0] = oneshot_q;
            end
            `FTL_A_STATUS: begin
                rd_mux[0] = valid_o;
                rd_mux[1] = holdoff_q;
                rd_mux[2] = locked_o;
                rd_mux[3] = (cmp_q == ftl_pkg::CMP_RECV);
                rd_mux[`FTL_ST_GOOD_LSB +: 3] = good_q;
                rd_mux[`FTL_ST_BAD_LSB +: 3]  = bad_q;
            end
            `FTL_A_TIMER: begin
                rd_mux[23:0] = os_cnt_q;
            end
            `FTL_A_PATCNT: begin
                rd_mux = {bad_tot_q, good_tot_q};
            end
            default: begin
                rd_mux = 32'h00000000;
            end
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_o <= 32'h00000000;
        end else if (ce_i) begin
            rdata_o <= re_i ? rd_mux : 32'h00000000;
        end
    end
endmodule
`default_nettype wire

// File: ftl_defines.svh
// Constants for the tone-coded remote link: timing, pattern layout, register map.
`ifndef FTL_DEFINES_SVH
`define FTL_DEFINES_SVH

// Oscillator tick taken every fourth clock so tones pass the pin filter
`define FTL_OSC_DIV      2'd3
// Symbol slot is 64 oscillator ticks, 32 high-tone periods
`define FTL_SYM_LAST     6'd63
`define FTL_POS_SYNC     4'd15
`define FTL_BIT_LAST     4'd15
// Period classes measured in clocks between rising edges
`define FTL_HF_MAX       5'd12
`define FTL_LF_MAX       5'd20
`define FTL_PER_SAT      5'd21
`define FTL_HF_ONE       6'd32
`define FTL_HF_ZERO      6'd16
`define FTL_LF_ZERO      5'd8
`define FTL_LF_SYNC      5'd16
// Mask-set bits of positions 3..5
`define FTL_MASK_BITS    3'b101
`define FTL_GOOD_TRIG    3'd3
`define FTL_BAD_TRIG     3'd3
`define FTL_CNT_MAX      3'd7
// One-shot time and clock rate
`define FTL_ONESHOT_US   500000
`define FTL_CLK_MHZ      10
// Register byte addresses
`define FTL_A_CTRL       8'h00
`define FTL_A_ONESHOT    8'h04
`define FTL_A_STATUS     8'h08
`define FTL_A_TIMER      8'h0c
`define FTL_A_PATCNT     8'h10
// Field positions
`define FTL_CTRL_SEND    0
`define FTL_CTRL_DEC_EN  1
`define FTL_CTRL_RST     2'b10
`define FTL_ST_GOOD_LSB  4
`define FTL_ST_BAD_LSB   8

`endif

// File: ftl_pkg.sv
// Types shared by the encoder, the tone receiver and the link top.
package ftl_pkg;

    typedef enum logic [1:0] {SYM_ONE, SYM_ZERO, SYM_SYNC, SYM_BAD} ftl_sym_t;

    typedef struct packed {
        logic     stb;
        ftl_sym_t kind;
    } ftl_sym_ev_t;

    typedef struct packed {
        logic       key;
        logic       test;
        logic [8:0] enc_sel;
        logic [8:0] dec_sel;
        logic       rx;
    } ftl_pins_t;

    typedef enum logic {CMP_HUNT, CMP_RECV} ftl_cmp_state_t;

    // Data bits of positions 1..15, position 1 in bit 0
    function automatic logic [14:0] ftl_pattern_f(input logic [2:0] mask, input logic [8:0] sel);
        ftl_pattern_f = {1'b1, sel, mask, 2'b11};
    endfunction

endpackage

// File: ftl_encoder.sv
// Transmit encoder: sends the 16-symbol trinary pattern as two tones.
`timescale 1ns/1ps
`default_nettype none
`include "ftl_defines.svh"

module ftl_encoder (
    input  wire logic       clk_i,
    input  wire logic       arst_n_i,
    input  wire logic       ce_i,
    input  wire logic       active_i,
    input  wire logic       test_i,
    input  wire logic [8:0] sel_i,
    output logic            tx_o
);
    logic [1:0]  div_q;
    logic [5:0]  slot_q;
    logic [3:0]  pos_q;
    logic [14:0] pat;
    logic        tick;
    logic        is_sync;
    logic        hf;

    assign pat     = ftl_pkg::ftl_pattern_f(`FTL_MASK_BITS, sel_i);
    assign tick    = (div_q == `FTL_OSC_DIV);
    assign is_sync = (pos_q == `FTL_POS_SYNC);
    // A one is all high tone, a zero turns low in the second half
    assign hf      = !is_sync && (pat[pos_q] || !slot_q[5]);

    // Oscillator divider
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            div_q <= 2'h0;
        end else if (ce_i) begin
            div_q <= div_q + 2'h1;
        end
    end

    // Slot and position counters; test presets them
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            slot_q <= 6'h00;
            pos_q  <= 4'h0;
        end else if (ce_i) begin
            if (test_i || !active_i) begin
                slot_q <= 6'h00;
                pos_q  <= 4'h0;
            end else if (tick) begin
                slot_q <= slot_q + 6'h01;
                if (slot_q == `FTL_SYM_LAST) begin
                    pos_q <= pos_q + 4'h1;
                end
            end
        end
    end

    // High tone toggles every tick, low tone every second tick
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tx_o <= 1'b0;
        end else if (ce_i) begin
            if (test_i) begin
                tx_o <= 1'b1;
            end else if (!active_i) begin
                tx_o <= 1'b0;
            end else begin
                tx_o <= hf ? ~slot_q[0] : ~slot_q[1];
            end
        end
    end
endmodule
`default_nettype wire

// File: ftl_tone_rx.sv
// Tone receiver: times rising edges and turns tone runs into symbols.
`timescale 1ns/1ps
`default_nettype none
`include "ftl_defines.svh"

module ftl_tone_rx (
    input  wire logic         clk_i,
    input  wire logic         arst_n_i,
    input  wire logic         ce_i,
    input  wire logic         en_i,
    input  wire logic         rx_i,
    output ftl_pkg::ftl_sym_ev_t ev_o
);
    logic       prev_q;
    logic [4:0] per_q;
    logic [5:0] hf_q;
    logic [4:0] lf_q;
    logic       rise;
    logic       hf_p;
    logic       lf_p;
    logic       lost;
    logic       gap;

    assign rise = rx_i && !prev_q;
    assign hf_p = rise && (per_q <= `FTL_HF_MAX);
    assign lf_p = rise && (per_q > `FTL_HF_MAX) && (per_q <= `FTL_LF_MAX);
    assign lost = rise && (per_q > `FTL_LF_MAX);
    // Tone stopped in the middle of a symbol
    assign gap  = !rise && (per_q == `FTL_LF_MAX) && ((hf_q != 6'h00) || (lf_q != 5'h00));

    // Period timer between rising edges
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prev_q <= 1'b0;
            per_q  <= `FTL_PER_SAT;
        end else if (ce_i) begin
            prev_q <= rx_i;
            if (rise) begin
                per_q <= 5'h01;
            end else if (per_q != `FTL_PER_SAT) begin
                per_q <= per_q + 5'h01;
            end
        end
    end

    // Run counting; a break restarts alignment on the offending period
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hf_q <= 6'h00;
            lf_q <= 5'h00;
            ev_o <= '{stb: 1'b0, kind: ftl_pkg::SYM_BAD};
        end else if (ce_i) begin
            ev_o.stb <= 1'b0;
            if (!en_i || lost) begin
                hf_q <= 6'h00;
                lf_q <= 5'h00;
            end else if (gap) begin
                hf_q <= 6'h00;
                lf_q <= 5'h00;
                ev_o <= '{stb: 1'b1, kind: ftl_pkg::SYM_BAD};
            end else if (hf_p) begin
                if (lf_q != 5'h00) begin
                    hf_q <= 6'h01;
                    lf_q <= 5'h00;
                    ev_o <= '{stb: 1'b1, kind: ftl_pkg::SYM_BAD};
                end else if (hf_q + 6'h01 == `FTL_HF_ONE) begin
                    hf_q <= 6'h00;
                    ev_o <= '{stb: 1'b1, kind: ftl_pkg::SYM_ONE};
                end else begin
                    hf_q <= hf_q + 6'h01;
                end
            end else if (lf_p) begin
                if (hf_q == `FTL_HF_ZERO) begin
                    if (lf_q + 5'h01 == `FTL_LF_ZERO) begin
                        hf_q <= 6'h00;
                        lf_q <= 5'h00;
                        ev_o <= '{stb: 1'b1, kind: ftl_pkg::SYM_ZERO};
                    end else begin
                        lf_q <= lf_q + 5'h01;
                    end
                end else if (hf_q == 6'h00) begin
                    if (lf_q + 5'h01 == `FTL_LF_SYNC) begin
                        lf_q <= 5'h00;
                        ev_o <= '{stb: 1'b1, kind: ftl_pkg::SYM_SYNC};
                    end else begin
                        lf_q <= lf_q + 5'h01;
                    end
                end else begin
                    hf_q <= 6'h00;
                    lf_q <= 5'h01;
                    ev_o <= '{stb: 1'b1, kind: ftl_pkg::SYM_BAD};
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: ftl_link_monitor.sv
// Checker for the link top: bus strobes, tone timing and one-shot hold-off.
`timescale 1ns/1ps
`default_nettype none
module ftl_link_chk #(
    parameter int ONESHOT_CYC = 20000
) (
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    input  wire logic        ce_i,
    input  wire logic        test_i,
    input  wire logic        rx_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        we_i,
    input  wire logic        re_i,
    input  wire logic [31:0] rdata_o,
    input  wire logic        tx_o,
    input  wire logic        valid_o
);
    logic        tx_q;
    logic        rx_q;
    logic        rise_w;
    logic [5:0]  gap_q;
    logic [5:0]  quiet_q;
    logic [5:0]  idle_q;
    logic [31:0] off_q;
    logic [15:0] up_q;
    assign rise_w = tx_o & ~tx_q;
    // Saturating counters; the gap starts full so the first rise is not judged
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tx_q    <= 1'b0;
            rx_q    <= 1'b0;
            gap_q   <= 6'h3f;
            quiet_q <= 6'h0;
            idle_q  <= 6'h3f;
            off_q   <= ONESHOT_CYC;
            up_q    <= 16'h0;
        end else begin
            tx_q    <= tx_o;
            rx_q    <= rx_i;
            gap_q   <= rise_w ? 6'h0 : gap_q + {5'h0, ~&gap_q};
            quiet_q <= test_i ? 6'h0 : quiet_q + {5'h0, ~&quiet_q};
            idle_q  <= (rx_i != rx_q) ? 6'h0 : idle_q + {5'h0, ~&idle_q};
            off_q   <= valid_o ? 32'h0 : off_q + {31'h0, off_q < ONESHOT_CYC};
            up_q    <= up_q + {15'h0, ~&up_q};
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    sequence s_rd_miss;
        re_i && addr_i == 8'h14;
    endsequence
    sequence s_wr_rd;
        we_i && addr_i == 8'h04 ##1 re_i && addr_i == 8'h04;
    endsequence
    chk_rdata_idle: assert property (ce_i && !re_i |=> rdata_o == 32'h0)
        else $error("read data left standing");
    chk_unmapped_read: assert property (s_rd_miss |=> rdata_o == 32'h0)
        else $error("unmapped read not zero");
    chk_oneshot_rw: assert property (s_wr_rd |=> rdata_o == ($past(wdata_i, 2) & 32'h00ffffff))
        else $error("one-shot count not stored");
    chk_test_high: assert property (test_i [*8] |-> tx_o)
        else $error("test pin did not hold transmit high");
    chk_tone_period: assert property (rise_w && gap_q < 6'd40 && quiet_q == 6'h3f |-> gap_q == 6'd7 || gap_q == 6'd15)
        else $error("tone period not 8 or 16 clocks");
    chk_holdoff_off: assert property ($rose(valid_o) |-> off_q >= ONESHOT_CYC - 2)
        else $error("valid back on inside hold-off");
    chk_three_good: assert property ($rose(valid_o) |-> up_q > 16'd12288)
        else $error("valid on before three patterns");
    chk_rx_recent: assert property ($rose(valid_o) |-> idle_q < 6'd40)
        else $error("valid on without received tones");
endmodule
bind ftl_link ftl_link_chk #(.ONESHOT_CYC(ONESHOT_CYC)) i_chk (.clk_i, .arst_n_i, .ce_i, .test_i, .rx_i, .addr_i,
    .wdata_i, .we_i, .re_i, .rdata_o, .tx_o, .valid_o);
`default_nettype wire

// File: ftl_remote_model.sv
// Remote encoder model: sends the tone pattern of a chosen code on the receive line.
`timescale 1ns/1ps
`default_nettype none
module ftl_remote_model (
    input  wire logic       clk_i,
    input  wire logic       en_i,
    input  wire logic [8:0] sel_i,
    output logic            rx_o
);
    logic [11:0] cnt_q;
    logic [15:0] pat_w;
    // Index 15 is the sync slot; mask bits fixed at build time
    assign pat_w = {1'b0, 1'b1, sel_i, 3'b101, 2'b11};
    // Slot counter restarts at position 1 whenever the model is enabled
    always_ff @(posedge clk_i) begin
        cnt_q <= en_i ? cnt_q + 12'h1 : 12'h0;
    end
    // High tone period 8 clocks, low tone 16; a silent line sits low
    // Every tone run opens on a high half-period so no period is cut at a boundary
    always_comb begin
        if (!en_i) rx_o = 1'b0;
        else if (cnt_q[11:8] == 4'hf) rx_o = ~cnt_q[3];
        else if (pat_w[cnt_q[11:8]]) rx_o = ~cnt_q[2];
        else rx_o = cnt_q[7] ? ~cnt_q[3] : ~cnt_q[2];
    end
endmodule
`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the link top: registers, encoder tones and decoder one-shot.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int OS = 10000;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        key = 1'b0;
    logic        test = 1'b0;
    logic        lb = 1'b0;
    logic        m_en = 1'b0;
    logic [8:0]  enc_sel = 9'h0;
    logic [8:0]  m_sel = 9'h0;
    logic [7:0]  addr = 8'h0;
    logic [31:0] wdata = 32'h0;
    logic        we = 1'b0;
    logic        re = 1'b0;
    logic [31:0] rdata;
    logic        tx;
    logic        valid;
    logic        m_rx;
    logic        locked;
    int          num_errors = 0;
    int          total_checks = 0;
    wire logic   rx = lb ? tx : m_rx;
    always #50 clk = ~clk;
    ftl_link #(.ONESHOT_CYC(OS)) i_dut (.clk_i(clk), .arst_n_i(arst_n), .ce_i(1'b1), .key_i(key), .test_i(test),
        .enc_sel_i(enc_sel), .dec_sel_i(9'h0a5), .rx_i(rx), .addr_i(addr), .wdata_i(wdata), .we_i(we),
        .re_i(re), .rdata_o(rdata), .tx_o(tx), .valid_o(valid), .locked_o(locked));
    ftl_remote_model i_far (.clk_i(clk), .en_i(m_en), .sel_i(m_sel), .rx_o(m_rx));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Write strobe is dropped by the next access, so a readback follows with no gap
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        re <= 1'b0;
        we <= 1'b1;
        addr <= a;
        wdata <= d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        we <= 1'b0;
        re <= 1'b1;
        addr <= a;
        @(posedge clk);
        re <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd(a, d);
        check(d, e);
    endtask
    // Bounded wait for the valid output to reach a level
    task automatic wait_lvl(input logic lvl, input int lim, output int n);
        n = 0;
        while (valid !== lvl && n < lim) begin
            @(posedge clk);
            n++;
        end
        check(valid, lvl);
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Watchdog of 100000 clocks, short of the 102856 that the wait limits of the sequence below allow
    initial begin
        #10000000;
        num_errors++;
        final_report();
    end
    initial begin
        logic [31:0] st;
        logic        prev;
        int          n;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        rdc(8'h00, 32'h2);
        rdc(8'h04, OS);
        rdc(8'h14, 32'h0);
        wr(8'h04, OS + 1);
        rdc(8'h04, OS + 1);
        wr(8'h10, 32'h0);
        rdc(8'h10, 32'h0);
        $display("registers done");
        // Rising tone edges in one pattern length depend only on the code
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            enc_sel <= i ? 9'h1ff : 9'h0a5;
            key <= !i;
            if (i) wr(8'h00, 32'h3);
            if (i) rdc(8'h00, 32'h3);
            repeat (64) @(posedge clk);
            n = 0;
            prev = tx;
            repeat (4096) begin
                @(posedge clk);
                n += int'(tx === 1'b1 && prev === 1'b0);
                prev = tx;
            end
            check(n, 416 + 8 * $countones(enc_sel));
            key <= 1'b0;
            if (i) wr(8'h00, 32'h2);
            if (i) rdc(8'h00, 32'h2);
            repeat (100) @(posedge clk);
        end
        key <= 1'b1;
        test <= 1'b1;
        repeat (10) @(posedge clk);
        n = 0;
        repeat (90) begin
            @(posedge clk);
            n += int'(tx !== 1'b1);
        end
        check(n, 0);
        test <= 1'b0;
        $display("encoder done");
        // Own encoder looped back: three good patterns turn valid on
        enc_sel <= 9'h0a5;
        lb <= 1'b1;
        wait_lvl(1'b1, 24000, n);
        check(locked, 1'b1);
        rd(8'h08, st);
        check(st & 32'h771, 32'h031);
        n = 0;
        repeat (12000) begin
            @(posedge clk);
            n += int'(valid !== 1'b1);
        end
        check(n, 0);
        // A wrong code ends valid; the right one is held off a full period
        m_sel <= 9'h0a4;
        m_en <= 1'b1;
        lb <= 1'b0;
        wait_lvl(1'b0, 24000, n);
        rd(8'h08, st);
        check(st & 32'h073, 32'h002);
        m_sel <= 9'h0a5;
        wait_lvl(1'b1, 24000, n);
        check(n >= OS - 8, 1'b1);
        rd(8'h08, st);
        check(st & 32'h701, 32'h001);
        m_en <= 1'b0;
        wait_lvl(1'b0, 10200, n);
        check(n > OS - 4200, 1'b1);
        check(locked, 1'b0);
        $display("decoder done");
        final_report();
    end
endmodule
`default_nettype wire
